// >>> logic/pll_ctrl_pkg.sv
// Shared constants and types for the clock synthesis loop control block
package pll_ctrl_pkg;

	// =====================================================================
	// Sizes
	localparam int REF_COUNT = 2;
	localparam int OUT_COUNT = 5;
	localparam int IRQ_WIDTH = 5;
	localparam int DIV_FIELD_WIDTH = 4;
	localparam int APB_ADDR_WIDTH = 8;

	// =====================================================================
	// Register offsets
	localparam logic [7:0] CONTROL_OFFSET = 8'h00;
	localparam logic [7:0] DIVIDE_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0C;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h10;

	// =====================================================================
	// Field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_DEDICATED_BIT = 2;
	localparam int STAT_LOCKED_BIT = 0;
	localparam int STAT_ACTIVE_BIT = 1;
	localparam int STAT_GOOD_LSB = 2;
	localparam int STAT_COMP_BIT = 4;
	localparam int STAT_STATE_LSB = 8;
	localparam int IRQ_LOCK_GAINED = 0;
	localparam int IRQ_LOCK_LOST = 1;
	localparam int IRQ_PRIMARY_BAD = 2;
	localparam int IRQ_BACKUP_BAD = 3;
	localparam int IRQ_SWITCHED = 4;

	// =====================================================================
	// Reset values and counts
	localparam logic [1:0] MODE_RESET = 2'h2;
	localparam logic DEDICATED_RESET = 1'b1;
	localparam logic [19:0] DIVIDE_RESET = 20'h00000;
	localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
	localparam int LOCK_COUNT_DEFAULT = 16;
	localparam int SENSE_TIMEOUT_DEFAULT = 64;

	typedef enum logic [1:0] {
		MODE_SOURCE_SYNC = 2'h0,
		MODE_NO_COMP = 2'h1,
		MODE_NORMAL = 2'h2,
		MODE_ZERO_DELAY_BUFFER = 2'h3
	} comp_mode_t;

	typedef enum logic [3:0] {
		ST_RESET = 4'h1,
		ST_ACQUIRE = 4'h2,
		ST_LOCKED = 4'h4,
		ST_HOLD = 4'h8
	} loop_state_t;

	// Half-period field of one output counter
	function automatic logic [DIV_FIELD_WIDTH-1:0] div_field(input logic [19:0] r, input int idx);
		div_field = r[idx*DIV_FIELD_WIDTH +: DIV_FIELD_WIDTH];
	endfunction

endpackage

// >>> logic/ref_sense_if.sv
// Link between the loop control and one reference clock sensor
`timescale 1ns/1ps
`default_nettype none
interface ref_sense_if;
	logic pinLevel;
	logic edgeSeen;
	logic good;
	modport sensor (input pinLevel, output edgeSeen, output good);
	modport owner (output pinLevel, input edgeSeen, input good);
endinterface // ref_sense_if
`default_nettype wire

// >>> logic/ref_sense.sv
// Reference clock activity sensor with two-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module ref_sense
	import pll_ctrl_pkg::*;
#(
	parameter int TIMEOUT = SENSE_TIMEOUT_DEFAULT
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clockEnable,
	ref_sense_if.sensor sense
);
	localparam int CW = $clog2(TIMEOUT + 1);

	if (TIMEOUT < 2) begin : g_bad_timeout
		$error("ref_sense: TIMEOUT must be at least 2");
	end

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic [CW-1:0] idle;
		logic edgeSeen;
		logic good;
	} sense_t;

	sense_t state_reg;
	sense_t state_next;

	// =====================================================================
	// Edge and timeout
	always_comb begin
		state_next = state_reg;
		state_next.sync1 = sense.pinLevel;
		state_next.sync2 = state_reg.sync1;
		state_next.prev = state_reg.sync2;
		state_next.edgeSeen = state_reg.sync2 & ~state_reg.prev;
		// RULE_19: stopped after timeout
		if (state_reg.sync2 & ~state_reg.prev) begin
			state_next.idle = '0;
			state_next.good = 1'b1;
		end else if (state_reg.idle == CW'(TIMEOUT - 1)) begin
			state_next.good = 1'b0;
		end else begin
			state_next.idle = state_reg.idle + CW'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= '0;
		end else if (clockEnable) begin
			state_reg <= state_next;
		end
	end

	assign sense.edgeSeen = state_reg.edgeSeen;
	assign sense.good = state_reg.good;

endmodule // ref_sense
`default_nettype wire

// >>> logic/pll_control.sv
// Control, status and output counters of the clock synthesis loop
// Function
// RULE_01: Active-high manual switch request from core logic changes the reference.
// RULE_02: Active-high loop reset from core logic resets loop, resyncs all counters.
// RULE_03: Phase detector enable high passes detector activity; low gates it off.
// RULE_04: Five output counter clocks; only counter zero drives the external output.
// RULE_05: One health flag per reference, bit 0 primary; 1 toggling, 0 stopped.
// RULE_06: Active-high lock indication from the lock detector to core logic.
// RULE_07: Selected reference indicator low for primary, high for backup.
// RULE_08: References come only from dedicated pins, loops or pin-driven globals.
// RULE_09: Four compensation modes, each keeping divide, phase and duty features.
// RULE_10: Full compensation only when reference comes from dedicated clock pins.
// RULE_11: Source-synchronous mode keeps clock/data phase at input registers.
// RULE_12: No-compensation mode: outputs aligned together, may lead or lag reference.
// RULE_13: Normal mode aligns internal clocks; external output shows a phase offset.
// RULE_14: Zero-delay-buffer mode aligns external output with reference pin.
// RULE_15: Reset holds counters, clears outputs, drops lock; release re-locks.
// RULE_16: Detector disabled: oscillator holds setting and keeps running.
// RULE_17: Absent current reference switches loop automatically to the other.
// RULE_18: Lock after configurable stable reference cycles; dropped at once on reset.
// RULE_19: Reference stopped when no edge within configurable sense count.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pll_control
	import pll_ctrl_pkg::*;
#(
	parameter int LOCK_COUNT = LOCK_COUNT_DEFAULT,
	parameter int SENSE_TIMEOUT = SENSE_TIMEOUT_DEFAULT
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clockEnable,
	input wire logic refClockPrimary,
	input wire logic refClockBackup,
	input wire logic switchRequest,
	input wire logic loopReset,
	input wire logic pfdEnable,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [OUT_COUNT-1:0] counterClock,
	output logic externalClock,
	output logic locked,
	output logic [REF_COUNT-1:0] clockGood,
	output logic activeClock,
	output logic compensated,
	output logic irq
);
	localparam int LW = $clog2(LOCK_COUNT + 1);

	if (LOCK_COUNT < 2) begin : g_bad_lock
		$error("pll_control: LOCK_COUNT must be at least 2");
	end

	typedef struct packed {
		loop_state_t state;
		logic activeSel;
		logic [LW-1:0] lockCount;
		comp_mode_t mode;
		logic dedicated;
		logic [19:0] divide;
		logic [OUT_COUNT-1:0][DIV_FIELD_WIDTH-1:0] phase;
		logic [OUT_COUNT-1:0] outClk;
		logic extOut;
		logic locked;
		logic [REF_COUNT-1:0] good;
		logic switchPrev;
		logic compensated;
		logic [IRQ_WIDTH-1:0] irqStatus;
		logic [IRQ_WIDTH-1:0] irqMask;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ctrl_t;

	ctrl_t state_reg;
	ctrl_t state_next;

	// =====================================================================
	// Reference sensors
	ref_sense_if senseBus[REF_COUNT]();

	assign senseBus[0].pinLevel = refClockPrimary;
	assign senseBus[1].pinLevel = refClockBackup;

	logic [REF_COUNT-1:0] refEdge;
	logic [REF_COUNT-1:0] refGood;

	for (genvar g = 0; g < REF_COUNT; g++) begin : g_sense
		ref_sense #(
			.TIMEOUT(SENSE_TIMEOUT)
		) u_sense (
			.clock(clock),
			.rst(rst),
			.clockEnable(clockEnable),
			.sense(senseBus[g])
		);
		assign refEdge[g] = senseBus[g].edgeSeen;
		assign refGood[g] = senseBus[g].good;
	end

	// =====================================================================
	// Register read decode
	function automatic logic [31:0] read_word(input ctrl_t s, input logic [7:0] addr);
		read_word = 32'h00000000;
		unique case (addr)
			CONTROL_OFFSET: begin
				read_word[CTRL_MODE_LSB +: 2] = s.mode;
				read_word[CTRL_DEDICATED_BIT] = s.dedicated;
			end
			DIVIDE_OFFSET: read_word[19:0] = s.divide;
			STATUS_OFFSET: begin
				read_word[STAT_LOCKED_BIT] = s.locked;
				read_word[STAT_ACTIVE_BIT] = s.activeSel;
				read_word[STAT_GOOD_LSB +: REF_COUNT] = s.good;
				read_word[STAT_COMP_BIT] = s.compensated;
				read_word[STAT_STATE_LSB +: 4] = s.state;
			end
			IRQ_STATUS_OFFSET: read_word[IRQ_WIDTH-1:0] = s.irqStatus;
			IRQ_MASK_OFFSET: read_word[IRQ_WIDTH-1:0] = s.irqMask;
			default: read_word = 32'h00000000;
		endcase
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr == CONTROL_OFFSET) || (addr == DIVIDE_OFFSET) ||
			(addr == STATUS_OFFSET) || (addr == IRQ_STATUS_OFFSET) ||
			(addr == IRQ_MASK_OFFSET);
	endfunction

	// =====================================================================
	// Next state
	logic apbDone;
	logic activeGood;
	logic otherGood;
	logic activeEdge;
	logic manualSwitch;
	logic autoSwitch;
	logic doSwitch;
	logic [IRQ_WIDTH-1:0] events;
	logic [IRQ_WIDTH-1:0] readClear;

	always_comb begin
		state_next = state_reg;
		apbDone = psel & penable & state_reg.pready;
		activeGood = state_reg.good[state_reg.activeSel];
		otherGood = state_reg.good[~state_reg.activeSel];
		activeEdge = refEdge[state_reg.activeSel];
		events = '0;
		readClear = '0;

		state_next.good = refGood;
		state_next.switchPrev = switchRequest;

		// RULE_01: manual switch on rising request
		manualSwitch = switchRequest & ~state_reg.switchPrev;
		// RULE_17: automatic switch to the other live reference
		autoSwitch = ~activeGood & otherGood;
		doSwitch = manualSwitch | autoSwitch;

		if (doSwitch) begin
			// RULE_07: selected reference indicator
			state_next.activeSel = ~state_reg.activeSel;
			state_next.lockCount = '0;
			events[IRQ_SWITCHED] = 1'b1;
		end

		unique case (state_reg.state)
			ST_RESET: begin
				state_next.state = ST_ACQUIRE;
			end
			ST_ACQUIRE: begin
				// RULE_18: count stable reference edges
				if (!pfdEnable) begin
					state_next.state = ST_HOLD;
				end else if (!activeGood) begin
					state_next.lockCount = '0;
				end else if (activeEdge && !doSwitch) begin
					if (state_reg.lockCount == LW'(LOCK_COUNT - 1)) begin
						state_next.state = ST_LOCKED;
						state_next.locked = 1'b1;
					end else begin
						state_next.lockCount = state_reg.lockCount + LW'(1);
					end
				end
			end
			ST_LOCKED: begin
				// RULE_03: detector gated off
				if (!pfdEnable) begin
					state_next.state = ST_HOLD;
				end else if (!activeGood || doSwitch) begin
					state_next.state = ST_ACQUIRE;
					state_next.locked = 1'b0;
					state_next.lockCount = '0;
				end
			end
			ST_HOLD: begin
				// RULE_16: hold and keep running
				if (!activeGood || doSwitch) begin
					state_next.locked = 1'b0;
				end
				if (pfdEnable) begin
					state_next.state = ST_ACQUIRE;
					state_next.locked = 1'b0;
					state_next.lockCount = '0;
				end
			end
			default: begin
				state_next.state = ST_RESET;
			end
		endcase

		// RULE_04: five counters from one oscillator
		for (int i = 0; i < OUT_COUNT; i++) begin
			if (state_reg.phase[i] == div_field(state_reg.divide, i)) begin
				state_next.phase[i] = '0;
				state_next.outClk[i] = ~state_reg.outClk[i];
			end else begin
				state_next.phase[i] = state_reg.phase[i] + DIV_FIELD_WIDTH'(1);
			end
		end

		// RULE_02: reset resyncs every counter
		// RULE_15: hold counters, clear outputs, drop lock
		if (loopReset) begin
			state_next.state = ST_RESET;
			state_next.locked = 1'b0;
			state_next.lockCount = '0;
			state_next.phase = '0;
			state_next.outClk = '0;
		end

		// RULE_13: external output lags in normal mode
		// RULE_14: zero-delay-buffer aligns external output
		// RULE_12: no-compensation keeps counters aligned
		if (state_reg.mode == MODE_NORMAL) begin
			state_next.extOut = state_reg.outClk[0] & ~loopReset;
		end else begin
			state_next.extOut = state_next.outClk[0];
		end

		// RULE_10: full compensation needs dedicated pins
		// RULE_11: source-synchronous mode compensated too
		state_next.compensated = state_reg.dedicated && (state_reg.mode != MODE_NO_COMP) &&
			state_reg.locked;

		// Interrupt events
		events[IRQ_LOCK_GAINED] = ~state_reg.locked & state_next.locked;
		events[IRQ_LOCK_LOST] = state_reg.locked & ~state_next.locked;
		// RULE_05: health flags per reference
		events[IRQ_PRIMARY_BAD] = state_reg.good[0] & ~refGood[0];
		events[IRQ_BACKUP_BAD] = state_reg.good[1] & ~refGood[1];

		// APB access phase, one wait-free answer
		state_next.pready = psel & ~penable;
		if (psel && !penable) begin
			state_next.prdata = read_word(state_reg, paddr);
			state_next.pslverr = ~mapped(paddr);
		end else begin
			state_next.pslverr = 1'b0;
		end

		if (apbDone && pwrite && mapped(paddr)) begin
			unique case (paddr)
				CONTROL_OFFSET: begin
					// RULE_09: mode choice keeps divide features
					state_next.mode = comp_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
					state_next.dedicated = pwdata[CTRL_DEDICATED_BIT];
				end
				DIVIDE_OFFSET: state_next.divide = pwdata[19:0];
				IRQ_MASK_OFFSET: state_next.irqMask = pwdata[IRQ_WIDTH-1:0];
				default: state_next.irqMask = state_reg.irqMask;
			endcase
		end

		// Clear only what the read returned; new events win
		if (apbDone && !pwrite && paddr == IRQ_STATUS_OFFSET) begin
			readClear = state_reg.prdata[IRQ_WIDTH-1:0];
		end
		state_next.irqStatus = (state_reg.irqStatus & ~readClear) | events;
		state_next.irq = |(state_next.irqStatus & state_next.irqMask);
	end

	// =====================================================================
	// State register
	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.state <= ST_RESET;
			state_reg.mode <= comp_mode_t'(MODE_RESET);
			state_reg.dedicated <= DEDICATED_RESET;
			state_reg.divide <= DIVIDE_RESET;
			state_reg.irqMask <= IRQ_MASK_RESET;
		end else if (clockEnable) begin
			state_reg <= state_next;
		end
	end

	// =====================================================================
	// Outputs
	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign counterClock = state_reg.outClk;
	assign externalClock = state_reg.extOut;
	// RULE_06: lock indication
	assign locked = state_reg.locked;
	assign clockGood = state_reg.good;
	assign activeClock = state_reg.activeSel;
	assign compensated = state_reg.compensated;
	assign irq = state_reg.irq;

endmodule // pll_control
`default_nettype wire

// >>> verif/ref_clock_source.sv
// Model of the two reference clock pins
`timescale 1ns/1ps
`default_nettype none
module ref_clock_source #(
	parameter int HALF0 = 2,
	parameter int HALF1 = 3
) (
	input wire logic clock,
	input wire logic [1:0] run,
	output logic refClockPrimary,
	output logic refClockBackup
);
	int n0 = 0;
	int n1 = 0;
	initial refClockPrimary = 1'h0;
	initial refClockBackup = 1'h0;
	always @(posedge clock) begin
		n0 <= (n0 >= HALF0 - 1) ? 0 : n0 + 1;
		n1 <= (n1 >= HALF1 - 1) ? 0 : n1 + 1;
		if (run[0] && n0 == 0)
			refClockPrimary <= !refClockPrimary;
		if (run[1] && n1 == 0)
			refClockBackup <= !refClockBackup;
	end
endmodule // ref_clock_source
`default_nettype wire

// >>> verif/pll_control_asserts.sv
// Port checks of the loop control block
`timescale 1ns/1ps
`default_nettype none
module pll_control_asserts
	import pll_ctrl_pkg::*;
#(
	parameter int LOCK_COUNT = LOCK_COUNT_DEFAULT,
	parameter int SENSE_TIMEOUT = SENSE_TIMEOUT_DEFAULT
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clockEnable,
	input wire logic refClockPrimary,
	input wire logic refClockBackup,
	input wire logic switchRequest,
	input wire logic loopReset,
	input wire logic pfdEnable,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [OUT_COUNT-1:0] counterClock,
	input wire logic externalClock,
	input wire logic locked,
	input wire logic [REF_COUNT-1:0] clockGood,
	input wire logic activeClock,
	input wire logic compensated
);
	int primaryIdle;
	int backupIdle;
	int lockAge;
	logic primaryPrev;
	logic backupPrev;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// =====================================================================
	// Idle and lock age counters
	always_ff @(posedge clock) begin
		primaryPrev <= refClockPrimary;
		backupPrev <= refClockBackup;
		primaryIdle <= (rst || refClockPrimary != primaryPrev) ? 0 : primaryIdle + 1;
		backupIdle <= (rst || refClockBackup != backupPrev) ? 0 : backupIdle + 1;
		lockAge <= (rst || loopReset) ? 0 : lockAge + 1;
	end

	// =====================================================================
	// Assertions
	reset_clears_a:
	assert property (loopReset && clockEnable |=> !locked && counterClock == '0 && !externalClock)
		else $error("loop reset left outputs active");
	lock_delay_a:
	assert property (lockAge < 3 * LOCK_COUNT |-> !locked)
		else $error("lock came too early");
	pfd_gate_a:
	assert property (!pfdEnable && !$past(pfdEnable) && !locked |=> !locked)
		else $error("lock gained with detector off");
	primary_good_a:
	assert property (primaryIdle > SENSE_TIMEOUT + 16 |-> !clockGood[0])
		else $error("stopped primary still good");
	backup_good_a:
	assert property (backupIdle > SENSE_TIMEOUT + 16 |-> !clockGood[1])
		else $error("stopped backup still good");
	auto_switch_a:
	assert property (!activeClock && !clockGood[0] && clockGood[1] && !loopReset
		|-> ##[1:4] activeClock)
		else $error("no switch to backup");
	manual_switch_a:
	assert property ($rose(switchRequest) && !loopReset |-> ##[1:4] $changed(activeClock))
		else $error("manual switch ignored");
	comp_drop_a:
	assert property ($fell(locked) |=> !compensated)
		else $error("compensated without lock");
	freeze_hold_a:
	assert property (!clockEnable |=> $stable(counterClock) && $stable(locked))
		else $error("state moved while frozen");
	apb_ready_a:
	assert property (psel && !penable && clockEnable |=> pready)
		else $error("access phase without ready");

	cover property ($rose(locked));
	cover property ($rose(activeClock));
	cover property (pready && pslverr);
endmodule // pll_control_asserts
bind pll_control pll_control_asserts #(.LOCK_COUNT(LOCK_COUNT),
	.SENSE_TIMEOUT(SENSE_TIMEOUT)) i_pll_control_asserts (
	.clock(clock), .rst(rst), .clockEnable(clockEnable),
	.refClockPrimary(refClockPrimary), .refClockBackup(refClockBackup),
	.switchRequest(switchRequest), .loopReset(loopReset), .pfdEnable(pfdEnable),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.counterClock(counterClock), .externalClock(externalClock), .locked(locked),
	.clockGood(clockGood), .activeClock(activeClock), .compensated(compensated));
`default_nettype wire

// >>> verif/pll_control_tb.sv
// Self-checking bench for the loop control block
`timescale 1ns/1ps
`default_nettype none
module pll_control_tb
	import pll_ctrl_pkg::*;
();
	logic clock = 1'h0;
	logic rst, clockEnable, switchRequest, loopReset, pfdEnable;
	logic refClockPrimary, refClockBackup;
	logic psel, penable, pwrite, pready, pslverr, err;
	logic [APB_ADDR_WIDTH-1:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed, word;
	logic [OUT_COUNT-1:0] counterClock, prev;
	logic externalClock, locked, activeClock, compensated, irq;
	logic [REF_COUNT-1:0] clockGood, run;
	int n_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int extMiss;
	int cnt[5];

	pll_control #(.LOCK_COUNT(4), .SENSE_TIMEOUT(16)) i_pll_control (
		.clock(clock), .rst(rst), .clockEnable(clockEnable),
		.refClockPrimary(refClockPrimary), .refClockBackup(refClockBackup),
		.switchRequest(switchRequest), .loopReset(loopReset), .pfdEnable(pfdEnable),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .counterClock(counterClock),
		.externalClock(externalClock), .locked(locked), .clockGood(clockGood),
		.activeClock(activeClock), .compensated(compensated), .irq(irq)
	);
	ref_clock_source i_ref_clock_source (.clock(clock), .run(run),
		.refClockPrimary(refClockPrimary), .refClockBackup(refClockBackup));

	always #2.5 clock = !clock;

	// =====================================================================
	// Expectations and bus tasks
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic compExp(input logic [31:0] w);
		return w[CTRL_DEDICATED_BIT] && (w[1:0] != MODE_NO_COMP);
	endfunction
	function automatic logic pick(input int k);
		case (k)
			0: return locked;
			1: return activeClock;
			2: return clockGood[0];
			default: return irq;
		endcase
	endfunction

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic waitFor(input string name, input int k, input logic v);
		int n;
		n = 0;
		while (pick(k) !== v && n < 400) begin
			@(posedge clock);
			n++;
		end
		chk(name, 32'(v), 32'(pick(k)));
	endtask
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge clock);
		penable <= 1'h1;
		do @(posedge clock); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			print_verdict();
		end
	end

	// =====================================================================
	// Main sequence
	initial begin
		{rst, clockEnable, loopReset, switchRequest, pfdEnable} = 5'h1C;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		run = 2'h1;
		seed = 32'h27;
		repeat (10) @(posedge clock);
		rst <= 1'h0;
		repeat (5) @(posedge clock);
		chk("heldLock", 32'h0, 32'(locked));
		chk("heldCount", 32'h0, 32'(counterClock));
		apb(1'h0, CONTROL_OFFSET, 32'h0);
		chk("ctrl", 32'({DEDICATED_RESET, MODE_RESET}), rd);
		apb(1'h0, 8'h14, 32'h0);
		chk("unmapped", 32'h1, 32'(err));
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			apb(1'h1, DIVIDE_OFFSET, seed);
			apb(1'h0, DIVIDE_OFFSET, 32'h0);
			chk("divide", seed & 32'hFFFFF, rd);
			apb(1'h1, IRQ_MASK_OFFSET, seed & 32'h1E);
			apb(1'h0, IRQ_MASK_OFFSET, 32'h0);
			chk("mask", seed & 32'h1E, rd);
		end
		loopReset <= 1'h0;
		repeat (30) @(posedge clock);
		chk("gated", 32'h0, 32'(locked));
		pfdEnable <= 1'h1;
		waitFor("locked", 0, 1'h1);
		apb(1'h0, STATUS_OFFSET, 32'h0);
		chk("status", {20'h0, ST_LOCKED, 8'h15}, rd);
		apb(1'h0, IRQ_STATUS_OFFSET, 32'h0);
		chk("lockEvent", 32'h1, rd & 32'h1);
		chk("irqMasked", 32'h0, 32'(irq));
		apb(1'h1, IRQ_MASK_OFFSET, 32'h1F);
		run <= 2'h3;
		apb(1'h1, DIVIDE_OFFSET, 32'h43210);
		pfdEnable <= 1'h0;
		repeat (20) @(posedge clock);
		prev = counterClock;
		extMiss = 0;
		cnt = '{default: 0};
		repeat (60) begin
			@(posedge clock);
			extMiss += int'(externalClock !== prev[0]);
			for (int i = 0; i < 5; i++)
				cnt[i] += int'(counterClock[i] !== prev[i]);
			prev = counterClock;
		end
		for (int i = 0; i < 5; i++)
			chk("toggles", 60 / (i + 1), cnt[i]);
		chk("extLag", 32'h0, extMiss);
		chk("holdover", 32'h1, 32'(locked));
		pfdEnable <= 1'h1;
		repeat (4) @(posedge clock);
		waitFor("relock", 0, 1'h1);
		for (int m = 0; m < 5; m++) begin
			word = (m < 4) ? 32'(m) | 32'h4 : 32'h2;
			apb(1'h1, CONTROL_OFFSET, word);
			repeat (3) @(posedge clock);
			chk("comp", 32'(compExp(word)), 32'(compensated));
			chk("extAlign", 32'(word[1:0] != MODE_NORMAL),
				32'(externalClock === counterClock[0]));
		end
		apb(1'h1, CONTROL_OFFSET, 32'h6);
		clockEnable <= 1'h0;
		repeat (6) @(posedge clock);
		clockEnable <= 1'h1;
		run <= 2'h2;
		waitFor("primaryBad", 2, 1'h0);
		waitFor("autoSwitch", 1, 1'h1);
		waitFor("irqUp", 3, 1'h1);
		apb(1'h0, IRQ_STATUS_OFFSET, 32'h0);
		chk("swEvents", 32'h14, rd & 32'h1C);
		waitFor("backupLock", 0, 1'h1);
		apb(1'h0, IRQ_STATUS_OFFSET, 32'h0);
		repeat (2) @(posedge clock);
		chk("irqClear", 32'h0, 32'(irq));
		run <= 2'h3;
		waitFor("primaryGood", 2, 1'h1);
		switchRequest <= 1'h1;
		waitFor("manualSw", 1, 1'h0);
		switchRequest <= 1'h0;
		waitFor("primaryLock", 0, 1'h1);
		loopReset <= 1'h1;
		repeat (2) @(posedge clock);
		chk("dropLock", 32'h0, 32'(locked));
		chk("resetCount", 32'h0, 32'(counterClock));
		loopReset <= 1'h0;
		waitFor("finalLock", 0, 1'h1);
		print_verdict();
	end
endmodule // pll_control_tb
`default_nettype wire
